/* File: include/serial_port_defs.svh */
// Register indices, field positions, reset values and sampling counts of the serial port.
// Assumes a byte-addressed register port where each register sits at four times its index.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// Register indices; the byte address is the index shifted left by two.
`define BAUD_DIVISOR_IDX  6'h09
`define CONTROL_IDX       6'h0a
`define STATUS_IDX        6'h0b
`define DATA_IDX          6'h0c
`define IRQ_STATUS_IDX    6'h0d
`define IRQ_CLEAR_IDX     6'h0e
`define IRQ_ENABLE_IDX    6'h0f

// Reset values.
`define BAUD_RESET        8'h00
`define CONTROL_RESET     8'h00
`define IRQ_ENABLE_RESET  8'h00

// Status and interrupt enable field positions.
`define STAT_RX_DONE_BIT  7
`define STAT_TXC_BIT      6
`define IRQ_GLOBAL_BIT    7

// Oversampling: sixteen ticks per bit, majority vote over ticks 7, 8 and 9.
`define LAST_TICK         4'hf
`define VOTE_FIRST        4'h7
`define VOTE_LAST         4'h9
`define LAST_BIT_8        4'h7
`define LAST_BIT_9        4'h8
`define STOP_IDX_8        4'h9
`define STOP_IDX_9        4'ha

`endif

/* File: include/serial_port_pkg.sv */
// Types shared by the serial port control logic.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_port_pkg;

   // Control register layout, bit 7 first.
   typedef struct packed {
      logic rx_irq_enable;
      logic txc_irq_enable;
      logic tx_empty_irq_enable;
      logic receiver_enable;
      logic transmitter_enable;
      logic nine_bit_char_select;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
   } ctrl_t;

   // Sticky event bits, shared by the interrupt status, clear and enable registers.
   typedef struct packed {
      logic overrun;
      logic framing;
      logic tx_done;
      logic rx_done;
   } irq_bits_t;

   typedef enum logic [1:0] {
      rx_idle  = 2'b00,
      rx_start = 2'b01,
      rx_data  = 2'b10,
      rx_stop  = 2'b11
   } rx_state_t;

   typedef enum logic {
      tx_idle  = 1'b0,
      tx_shift = 1'b1
   } tx_state_t;

endpackage

/* File: logic/baud_tick_gen.sv */
// Down-counter that divides the system clock into the sixteen-times bit rate tick.
// Assumes the divisor comes from a register on the same clock.
module baud_tick_gen #(
   parameter int unsigned DIV_W = 8
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Divisor and tick.
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick
);

   logic [DIV_W-1:0] count_q;
   logic [DIV_W-1:0] count_d;
   logic             tick_d;

   // A new divisor is only picked up at a reload, so a write never shortens a period.
   always_comb begin
      tick_d = 1'b0;
      if (count_q == '0) begin
         count_d = divisor;
         tick_d  = 1'b1;
      end else begin
         count_d = count_q - {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // Registers only.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_q <= '0;
         tick    <= 1'b0;
      end else begin
         count_q <= count_d;
         tick    <= tick_d;
      end
   end

endmodule

/* File: logic/serial_port_ctrl.sv */
// Control registers, baud generator, transmitter and receiver of an asynchronous serial port.
// Assumes a single-cycle register port master on the same clock and an asynchronous rxd pin.
//
// What this block does
// - Request the empty interrupt while enabled, globally enabled, and transmit buffer empty.
// - Receiver works only when enabled; otherwise complete, overrun, framing flags never set.
// - Disabling the receiver leaves already set flags untouched.
// - Transmitter accepts characters only while its enable bit is one.
// - Disabling the transmitter still finishes the shifting and the pending character.
// - Nine-bit select gives nine data bits, one start and one stop bit.
// - In nine-bit mode the received ninth bit reads in the control register.
// - In nine-bit mode the transmit ninth-bit field is sent as ninth bit.
// - Bit rate is clock over sixteen times divisor plus one.
// - The divisor is an eight-bit read/write register that resets to zero.
// - The receiver samples rxd at sixteen times the bit rate using the tick.
// - The received ninth bit loads when the character moves to the data register.
`include "serial_port_defs.svh"

module serial_port_ctrl (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Register port.
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // Serial pins.
   input  wire logic       rxd,
   output logic            txd,
   output logic            tx_owns_pin,
   // Interrupt.
   output logic            irq
);

   // Address decode.
   logic sel_baud;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_data;
   logic sel_isr;
   logic sel_iclr;
   logic sel_ien;

   assign sel_baud = (addr == {`BAUD_DIVISOR_IDX, 2'b00});
   assign sel_ctrl = (addr == {`CONTROL_IDX, 2'b00});
   assign sel_stat = (addr == {`STATUS_IDX, 2'b00});
   assign sel_data = (addr == {`DATA_IDX, 2'b00});
   assign sel_isr  = (addr == {`IRQ_STATUS_IDX, 2'b00});
   assign sel_iclr = (addr == {`IRQ_CLEAR_IDX, 2'b00});
   assign sel_ien  = (addr == {`IRQ_ENABLE_IDX, 2'b00});

   // Register group state.
   serial_port_pkg::ctrl_t     ctrl_q;
   serial_port_pkg::ctrl_t     ctrl_d;
   logic [7:0]                 baud_q;
   logic [7:0]                 baud_d;
   logic [7:0]                 ien_q;
   logic [7:0]                 ien_d;
   serial_port_pkg::irq_bits_t isr_q;
   serial_port_pkg::irq_bits_t isr_d;
   serial_port_pkg::irq_bits_t events;
   logic [7:0]                 rdata_d;
   logic                       irq_d;

   // Transmitter state.
   serial_port_pkg::tx_state_t tx_state_q;
   serial_port_pkg::tx_state_t tx_state_d;
   logic [10:0]                tx_shift_q;
   logic [10:0]                tx_shift_d;
   logic [3:0]                 tx_tick_q;
   logic [3:0]                 tx_tick_d;
   logic [3:0]                 tx_bit_q;
   logic [3:0]                 tx_bit_d;
   logic [7:0]                 tx_buf_q;
   logic [7:0]                 tx_buf_d;
   logic                       buf_full_q;
   logic                       buf_full_d;
   logic                       txc_q;
   logic                       txc_d;
   logic                       txd_d;
   logic                       owns_d;
   logic                       tx_load;
   logic                       tx_done_ev;

   // Receiver state.
   serial_port_pkg::rx_state_t rx_state_q;
   serial_port_pkg::rx_state_t rx_state_d;
   logic [3:0]                 rx_tick_q;
   logic [3:0]                 rx_tick_d;
   logic [1:0]                 vote_q;
   logic [1:0]                 vote_d;
   logic [1:0]                 vote_n;
   logic                       majority;
   logic [3:0]                 rx_bit_q;
   logic [3:0]                 rx_bit_d;
   logic [8:0]                 rx_shift_q;
   logic [8:0]                 rx_shift_d;
   logic [7:0]                 rx_data_q;
   logic [7:0]                 rx_data_d;
   logic                       rxc_q;
   logic                       rxc_d;
   logic                       fe_q;
   logic                       fe_d;
   logic                       ovr_q;
   logic                       ovr_d;
   logic                       rx_xfer;
   logic                       rx_end;
   logic                       rxd_meta_q;
   logic                       rxd_s;
   logic                       tick;

   // Shared strobes.
   logic data_read;
   logic nine;

   assign data_read = rd && sel_data;
   assign nine      = ctrl_q.nine_bit_char_select;

   // Sixteen-times tick for both directions.
   baud_tick_gen #(
      .DIV_W (8)
   ) u_baud (
      .clock   (clock),
      .rst_n   (rst_n),
      .divisor (baud_q),
      .tick    (tick)
   );

   // Two-stage synchroniser on the asynchronous receive pin.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxd_meta_q <= 1'b1;
         rxd_s      <= 1'b1;
      end else begin
         rxd_meta_q <= rxd;
         rxd_s      <= rxd_meta_q;
      end
   end

   // Register writes, sticky interrupt bits, read mux and interrupt level.
   always_comb begin
      ctrl_d  = ctrl_q;
      baud_d  = baud_q;
      ien_d   = ien_q;
      rdata_d = 8'h00;
      if (wr && sel_ctrl) begin
         ctrl_d              = serial_port_pkg::ctrl_t'(wdata);
         ctrl_d.rx_ninth_bit = ctrl_q.rx_ninth_bit;
      end
      if (rx_xfer && nine) begin
         ctrl_d.rx_ninth_bit = rx_shift_q[8];
      end
      if (wr && sel_baud) begin
         baud_d = wdata;
      end
      if (wr && sel_ien) begin
         ien_d = wdata;
      end
      events.overrun = rx_end && rxc_q;
      events.framing = rx_end && !majority;
      events.tx_done = tx_done_ev;
      events.rx_done = rx_end;
      // A clear in the same cycle as an event loses, so no event goes unseen.
      isr_d = isr_q;
      if (wr && sel_iclr) begin
         isr_d = isr_q & ~serial_port_pkg::irq_bits_t'(wdata[3:0]);
      end
      isr_d = isr_d | events;
      if (rd) begin
         case (1'b1)
            sel_baud: rdata_d = baud_q;
            sel_ctrl: rdata_d = {ctrl_q[7:1], 1'b0};
            sel_stat: rdata_d = {rxc_q, txc_q, !buf_full_q, fe_q, ovr_q, 3'b000};
            sel_data: rdata_d = rx_data_q;
            sel_isr:  rdata_d = {4'h0, isr_q};
            sel_ien:  rdata_d = ien_q;
            default:  rdata_d = 8'h00;
         endcase
      end
      irq_d = ien_q[`IRQ_GLOBAL_BIT] &&
              ((ctrl_q.tx_empty_irq_enable && !buf_full_q) ||
               (ctrl_q.rx_irq_enable && rxc_q) ||
               (ctrl_q.txc_irq_enable && txc_q) ||
               (|(isr_q & ien_q[3:0])));
   end

   // Registers only.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q <= serial_port_pkg::ctrl_t'(`CONTROL_RESET);
         baud_q <= `BAUD_RESET;
         ien_q  <= `IRQ_ENABLE_RESET;
         isr_q  <= '0;
         rdata  <= 8'h00;
         irq    <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         baud_q <= baud_d;
         ien_q  <= ien_d;
         isr_q  <= isr_d;
         rdata  <= rdata_d;
         irq    <= irq_d;
      end
   end

   // Transmitter: one holding byte plus an eleven-bit shift register, LSB first.
   always_comb begin
      tx_state_d = tx_state_q;
      tx_shift_d = tx_shift_q;
      tx_tick_d  = tx_tick_q;
      tx_bit_d   = tx_bit_q;
      tx_buf_d   = tx_buf_q;
      txc_d      = txc_q;
      tx_load    = 1'b0;
      tx_done_ev = 1'b0;
      if (wr && sel_stat && wdata[`STAT_TXC_BIT]) begin
         txc_d = 1'b0;
      end
      case (tx_state_q)
         serial_port_pkg::tx_idle: begin
            tx_load = buf_full_q;
         end
         serial_port_pkg::tx_shift: begin
            if (tick) begin
               tx_tick_d = tx_tick_q + 4'h1;
               if (tx_tick_q == `LAST_TICK) begin
                  tx_shift_d = {1'b1, tx_shift_q[10:1]};
                  tx_bit_d   = tx_bit_q + 4'h1;
                  if (tx_bit_q == (nine ? `STOP_IDX_9 : `STOP_IDX_8)) begin
                     if (buf_full_q) begin
                        tx_load = 1'b1;
                     end else begin
                        tx_state_d = serial_port_pkg::tx_idle;
                        if (ctrl_q.receiver_enable) begin
                           tx_done_ev = 1'b1;
                           txc_d      = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         default: begin
            tx_state_d = serial_port_pkg::tx_idle;
         end
      endcase
      if (tx_load) begin
         tx_state_d = serial_port_pkg::tx_shift;
         tx_shift_d = {1'b1, (nine ? ctrl_q.tx_ninth_bit : 1'b1), tx_buf_q, 1'b0};
         tx_tick_d  = 4'h0;
         tx_bit_d   = 4'h0;
      end
      // Writes are taken only while enabled; a write during a load refills the buffer.
      buf_full_d = buf_full_q && !tx_load;
      if (wr && sel_data && ctrl_q.transmitter_enable) begin
         tx_buf_d   = wdata;
         buf_full_d = 1'b1;
      end
      txd_d  = (tx_state_d == serial_port_pkg::tx_shift) ? tx_shift_d[0] : 1'b1;
      owns_d = ctrl_q.transmitter_enable || buf_full_d ||
               (tx_state_d == serial_port_pkg::tx_shift);
   end

   // Registers only.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_state_q  <= serial_port_pkg::tx_idle;
         tx_shift_q  <= '1;
         tx_tick_q   <= 4'h0;
         tx_bit_q    <= 4'h0;
         tx_buf_q    <= 8'h00;
         buf_full_q  <= 1'b0;
         txc_q       <= 1'b0;
         txd         <= 1'b1;
         tx_owns_pin <= 1'b0;
      end else begin
         tx_state_q  <= tx_state_d;
         tx_shift_q  <= tx_shift_d;
         tx_tick_q   <= tx_tick_d;
         tx_bit_q    <= tx_bit_d;
         tx_buf_q    <= tx_buf_d;
         buf_full_q  <= buf_full_d;
         txc_q       <= txc_d;
         txd         <= txd_d;
         tx_owns_pin <= owns_d;
      end
   end

   // Receiver: start detection, majority vote and transfer to the data register.
   always_comb begin
      rx_state_d = rx_state_q;
      rx_tick_d  = rx_tick_q;
      vote_d     = vote_q;
      rx_bit_d   = rx_bit_q;
      rx_shift_d = rx_shift_q;
      rx_data_d  = rx_data_q;
      rxc_d      = rxc_q;
      fe_d       = fe_q;
      ovr_d      = ovr_q;
      rx_xfer    = 1'b0;
      rx_end     = 1'b0;
      vote_n     = vote_q + {1'b0, (rx_tick_q >= `VOTE_FIRST) &&
                                   (rx_tick_q <= `VOTE_LAST) && rxd_s};
      majority   = vote_n[1];
      if (data_read) begin
         rxc_d = 1'b0;
      end
      // Dropping the enable only stops the state machine; the flags keep their values.
      if (!ctrl_q.receiver_enable) begin
         rx_state_d = serial_port_pkg::rx_idle;
      end else if (tick) begin
         rx_tick_d = rx_tick_q + 4'h1;
         vote_d    = (rx_tick_q == `LAST_TICK) ? 2'b00 : vote_n;
         case (rx_state_q)
            serial_port_pkg::rx_idle: begin
               rx_tick_d = 4'h1;
               vote_d    = 2'b00;
               if (!rxd_s) begin
                  rx_state_d = serial_port_pkg::rx_start;
               end
            end
            serial_port_pkg::rx_start: begin
               // Two ones among the three middle samples mark a noise spike.
               if ((rx_tick_q == `VOTE_LAST) && majority) begin
                  rx_state_d = serial_port_pkg::rx_idle;
               end else if (rx_tick_q == `LAST_TICK) begin
                  rx_state_d = serial_port_pkg::rx_data;
                  rx_bit_d   = 4'h0;
               end
            end
            serial_port_pkg::rx_data: begin
               if (rx_tick_q == `VOTE_LAST) begin
                  rx_shift_d = {majority, rx_shift_q[8:1]};
               end
               if (rx_tick_q == `LAST_TICK) begin
                  rx_bit_d = rx_bit_q + 4'h1;
                  if (rx_bit_q == (nine ? `LAST_BIT_9 : `LAST_BIT_8)) begin
                     rx_state_d = serial_port_pkg::rx_stop;
                  end
               end
            end
            serial_port_pkg::rx_stop: begin
               // Ending at the stop bit middle leaves half a bit to catch the next start.
               if (rx_tick_q == `VOTE_LAST) begin
                  rx_state_d = serial_port_pkg::rx_idle;
                  rx_end     = 1'b1;
                  fe_d       = !majority;
                  ovr_d      = rxc_q;
                  if (!rxc_q) begin
                     rx_xfer   = 1'b1;
                     rx_data_d = nine ? rx_shift_q[7:0] : rx_shift_q[8:1];
                  end
                  rxc_d = 1'b1;
               end
            end
            default: begin
               rx_state_d = serial_port_pkg::rx_idle;
            end
         endcase
      end
   end

   // Registers only.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_state_q <= serial_port_pkg::rx_idle;
         rx_tick_q  <= 4'h0;
         vote_q     <= 2'b00;
         rx_bit_q   <= 4'h0;
         rx_shift_q <= 9'h000;
         rx_data_q  <= 8'h00;
         rxc_q      <= 1'b0;
         fe_q       <= 1'b0;
         ovr_q      <= 1'b0;
      end else begin
         rx_state_q <= rx_state_d;
         rx_tick_q  <= rx_tick_d;
         vote_q     <= vote_d;
         rx_bit_q   <= rx_bit_d;
         rx_shift_q <= rx_shift_d;
         rx_data_q  <= rx_data_d;
         rxc_q      <= rxc_d;
         fe_q       <= fe_d;
         ovr_q      <= ovr_d;
      end
   end

endmodule

/* File: bench/serial_port_ctrl_sva.sv */
// Checker for the serial port control block, seeing only its top ports.
// Assumes the byte register map of the block; enables are copied from the write traffic.
module serial_port_ctrl_chk (
   // Clock and reset.
   input wire logic       clock,
   input wire logic       rst_n,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // Serial pins and interrupt.
   input wire logic       rxd,
   input wire logic       txd,
   input wire logic       tx_owns_pin,
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] en_q;
   logic [2:0] en_d;

   // Global, empty-interrupt and transmitter enables, copied because the registers are hidden.
   always_comb begin
      en_d = rst_n ? en_q : 3'h0;
      if (rst_n && wr && addr == 8'h3c) en_d[2] = wdata[7];
      if (rst_n && wr && addr == 8'h28) en_d[1:0] = {wdata[5], wdata[3]};
   end

   // Copy register.
   always_ff @(posedge clock) en_q <= en_d;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside an answer");
   chk_divisor_readback: assert property (
      wr && addr == 8'h24 ##1 rd && addr == 8'h24 |=> rdata == $past(wdata, 2))
      else $error("divisor read back differs from the value written");
   chk_ninth_wo_zero: assert property (rd && addr == 8'h28 |=> !rdata[0])
      else $error("write-only ninth bit reads as one");
   chk_irq_global_off: assert property (!en_q[2] |=> !irq)
      else $error("interrupt raised with global enable off");
   chk_irq_empty_on: assert property (en_q[2] && en_q[1] && !tx_owns_pin |-> ##[1:2] irq)
      else $error("empty interrupt missing while buffer is empty");
   chk_txd_idle_high: assert property (!tx_owns_pin |-> txd)
      else $error("line driven low while transmitter released it");
   chk_drain_holds: assert property (!en_q[0] && !txd |-> tx_owns_pin [*2])
      else $error("transmitter released pin in mid character");
   chk_data_starts: assert property (wr && addr == 8'h30 && en_q[0] |-> ##[1:1000] !txd)
      else $error("accepted character never started");
   chk_irq_needs_global: assert property ($rose(irq) |-> $past(en_q[2]))
      else $error("interrupt rose without the global enable set before it");

   cov_tx_write: cover property (wr && addr == 8'h30 && en_q[0]);
   cov_irq_rise: cover property ($rose(irq));
   cov_drain: cover property (!en_q[0] && !txd);
endmodule

bind serial_port_ctrl serial_port_ctrl_chk u_serial_port_ctrl_chk (.clock(clock),
   .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
   .txd(txd), .tx_owns_pin(tx_owns_pin), .irq(irq));

/* File: bench/remote_serial.sv */
// Model of the remote asynchronous transceiver on the far side of the serial pins.
// Assumes the bench changes bit length and character size only while both lines idle.
module remote_serial (
   // Clock.
   input  wire logic        clock,
   // Serial pins of the port.
   input  wire logic        txd,
   output logic             rxd,
   // Frame shape.
   input  wire logic [11:0] bit_clks,
   input  wire logic        nine
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] got[$];
   logic [9:0] w;
   int         n;

   initial rxd = 1'b1;

   // Sample each bit in its middle; the stop bit is stored as sent and never judged.
   always begin
      @(negedge txd);
      w = 10'h000;
      n = nine ? 10 : 9;
      repeat (bit_clks / 2) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         repeat (bit_clks) @(posedge clock);
         w[i] = txd;
      end
      got.push_back(w);
   end

   // One frame, low bit first; the stop level is the caller's, to allow a framing fault.
   task automatic send(input logic [8:0] d, input logic stop);
      logic [10:0] f;
      f = nine ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         rxd <= f[i];
         repeat (bit_clks) @(posedge clock);
      end
      rxd <= 1'b1;
      repeat (bit_clks) @(posedge clock);
   endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the serial port control block and a remote transceiver model.
// Assumes the byte register map of the block; divisor zero gives sixteen clocks a bit.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic       wr;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } row_t;
   logic        clock    = 1'b0;
   logic        rst_n    = 1'b0;
   logic [7:0]  addr     = 8'h00;
   logic [7:0]  wdata    = 8'h00;
   logic        wr       = 1'b0;
   logic        rd       = 1'b0;
   logic [11:0] bit_clks = 12'h010;
   logic        nine     = 1'b0;
   logic [7:0]  rdata;
   logic        rxd;
   logic        txd;
   logic        tx_owns_pin;
   logic        irq;
   logic [7:0]  v;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cycles   = 0;
   int          lo;
   row_t        rows[10];

   serial_port_ctrl u_serial_port_ctrl (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
      .tx_owns_pin(tx_owns_pin), .irq(irq));
   remote_serial u_remote_serial (.clock(clock), .txd(txd), .rxd(rxd), .bit_clks(bit_clks),
      .nine(nine));

   // 25 MHz clock.
   always #20 clock = ~clock;

   // The run needs a few thousand cycles, so this ceiling only trips on a hang.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 32'h7530) begin
         n_errors++;
         $display("[FAIL] cycles expected below %0d seen %0d", 32'h7530, cycles);
         summarize();
      end
   end

   task summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input string name, input logic [9:0] e, input logic [9:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, e, s);
      end
   endtask

   // Write, then an idle edge, so two writes in a row never assign wr twice at once.
   task reg_wr(input logic [7:0] a, input logic [7:0] d);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask

   // Read; the answer stands one cycle only, so it is taken mid-cycle.
   task rchk(input logic [7:0] a, input logic [7:0] e);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      v = rdata;
      @(posedge clock);
      chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, v});
   endtask

   task irq_chk(input logic e);
      repeat (2) @(negedge clock);
      chk("irq", {9'h000, e}, {9'h000, irq});
      @(posedge clock);
   endtask

   task word_chk(input logic [9:0] e);
      wait (u_remote_serial.got.size() > 0);
      chk("word on txd", e, u_remote_serial.got.pop_front());
      @(posedge clock);
   endtask

   // Rows: reset values, divisor access, control access with its read-only and write-only bits.
   initial begin
      rows = '{'{1'b0, 8'h24, 8'h00, 8'h00}, '{1'b0, 8'h28, 8'h00, 8'h00},
               '{1'b0, 8'h2c, 8'h00, 8'h20}, '{1'b0, 8'h3c, 8'h00, 8'h00},
               '{1'b1, 8'h24, 8'ha5, 8'ha5}, '{1'b1, 8'h28, 8'h1f, 8'h1c},
               '{1'b1, 8'h3c, 8'h8f, 8'h8f}, '{1'b1, 8'h25, 8'h77, 8'h00},
               '{1'b0, 8'h38, 8'h00, 8'h00}, '{1'b1, 8'h24, 8'h5c, 8'h5c}};
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      foreach (rows[i]) begin
         if (rows[i].wr)
            reg_wr(rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].e);
      end
      rst_n <= 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rchk(8'h24, 8'h00);
      rchk(8'h28, 8'h00);
      // Divisor two, written and read on consecutive edges, makes each bit 48 clocks.
      wr    <= 1'b1;
      addr  <= 8'h24;
      wdata <= 8'h02;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk("divisor", 10'h002, {2'b00, rdata});
      @(posedge clock);
      bit_clks <= 12'h030;
      reg_wr(8'h28, 8'h08);
      reg_wr(8'h30, 8'h00);
      @(negedge txd);
      lo = 0;
      while (!txd) begin
         @(negedge clock);
         lo++;
      end
      // The first tick after the load comes one to three clocks later, so the start bit may
      // fall up to two clocks short; the loop also counts one extra falling clock edge.
      chk("zero run", 10'h1b0, (lo >= 'h1af && lo <= 'h1b1) ? 10'h1b0 : 10'(lo));
      word_chk(10'h100);
      // Two characters back to back, then the transmitter is disabled while they drain.
      reg_wr(8'h24, 8'h00);
      // Let the old stop bit end first, as a write into a full buffer replaces its byte.
      repeat (20) @(posedge clock);
      bit_clks <= 12'h010;
      reg_wr(8'h30, 8'h5a);
      reg_wr(8'h30, 8'hc3);
      reg_wr(8'h28, 8'h00);
      word_chk(10'h15a);
      word_chk(10'h1c3);
      repeat (20) @(posedge clock);
      chk("owns pin", 10'h000, {9'h000, tx_owns_pin});
      rchk(8'h2c, 8'h20);
      reg_wr(8'h30, 8'h77);
      repeat (200) @(posedge clock);
      chk("words", 10'h000, 10'(u_remote_serial.got.size()));
      reg_wr(8'h28, 8'h18);
      reg_wr(8'h30, 8'h11);
      word_chk(10'h111);
      repeat (20) @(posedge clock);
      rchk(8'h2c, 8'h60);
      // Nine-bit characters in both directions.
      nine <= 1'b1;
      reg_wr(8'h28, 8'h1d);
      reg_wr(8'h30, 8'h3c);
      word_chk(10'h33c);
      u_remote_serial.send(9'h1a5, 1'b1);
      rchk(8'h30, 8'ha5);
      rchk(8'h28, 8'h1e);
      // Interrupt raised, cleared and masked.
      nine <= 1'b0;
      reg_wr(8'h28, 8'h18);
      reg_wr(8'h38, 8'h0f);
      reg_wr(8'h3c, 8'h81);
      u_remote_serial.send(9'h042, 1'b1);
      irq_chk(1'b1);
      rchk(8'h34, 8'h01);
      reg_wr(8'h38, 8'h01);
      rchk(8'h30, 8'h42);
      irq_chk(1'b0);
      reg_wr(8'h3c, 8'h80);
      reg_wr(8'h28, 8'h20);
      irq_chk(1'b1);
      reg_wr(8'h3c, 8'h00);
      irq_chk(1'b0);
      // Overrun with a framing fault, then the receiver is switched off.
      reg_wr(8'h28, 8'h18);
      reg_wr(8'h2c, 8'h40);
      u_remote_serial.send(9'h011, 1'b1);
      u_remote_serial.send(9'h022, 1'b0);
      reg_wr(8'h28, 8'h08);
      rchk(8'h2c, 8'hb8);
      u_remote_serial.send(9'h033, 1'b1);
      rchk(8'h30, 8'h11);
      rchk(8'h2c, 8'h38);
      summarize();
   end
endmodule
